//--- src/millisecond_watchdog.sv
// Millisecond watchdog with timeout/count and disable-key registers
//
// What this block does
// [R1] Count decrements once per millisecond tick
// [R2] 16-bit timeout, reset 1000, expiry resets
// [R3] Counts only in the active power state
// [R4] Timeout write accepted only with inverted upper half
// [R5] Software writes timeout with its complement
// [R6] Accepted timeout write restarts the countdown
// [R7] Expiry of enabled watchdog resets the tile
// [R8] Live count readable in upper sixteen bits
// [R9] Writing zero to disable register enables
// [R10] Disable key resets count and stops watchdog
// [R11] Comes out of reset disabled
// [R12] Tick derived from configured oscillator MHz
`timescale 1ns/10ps
`default_nettype none
module millisecond_watchdog (
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              srst,
  // Register access
  input  wire wdog_pkg::reg_req_t req,
  output var  wdog_pkg::reg_rsp_t rsp,
  // System state
  input  wire logic              active_power_state,
  input  wire logic [6:0]        osc_freq_mhz,
  // Reset request to the processor tile
  output var  logic              tile_reset
);
  import wdog_pkg::*;

  logic [15:0] timeout;
  logic [15:0] count;
  logic [31:0] disable_reg;
  logic        enabled;
  logic [6:0]  us_cnt;
  logic [9:0]  ms_cnt;
  logic        tick;
  logic        wr_timeout;
  logic        wr_disable;
  logic        timeout_ok;
  logic        expire;
  logic [6:0]  freq_last;

  // Write decode
  assign wr_timeout = req.valid && req.write && (req.index == TIMEOUT_REG_IDX);
  assign wr_disable = req.valid && req.write && (req.index == DISABLE_REG_IDX);
  assign timeout_ok = (req.wdata[31:HI_LSB] == ~req.wdata[LO_MSB:0]); // [R4]
  assign enabled    = (disable_reg != DISABLE_KEY);
  // Clamp frequency so a bad setting cannot stall the prescaler
  assign freq_last  = ((osc_freq_mhz < FREQ_MHZ_MIN) ? FREQ_MHZ_MIN :
                       (osc_freq_mhz > FREQ_MHZ_MAX) ? FREQ_MHZ_MAX : osc_freq_mhz) - 7'h01;

  // Prescaler: microsecond then millisecond, frozen outside active state
  always_ff @(posedge core_clk) begin
    if (srst || !enabled) begin
      us_cnt <= 7'h00;
      ms_cnt <= 10'h000;
    end else if (active_power_state) begin // [R3]
      if (us_cnt >= freq_last) begin // [R12]
        us_cnt <= 7'h00;
        ms_cnt <= (ms_cnt == TICK_US_LAST) ? 10'h000 : ms_cnt + 10'h001;
      end else begin
        us_cnt <= us_cnt + 7'h01;
      end
    end
  end
  assign tick = enabled && active_power_state && (us_cnt >= freq_last)
                && (ms_cnt == TICK_US_LAST); // [R1]

  // Timeout field
  always_ff @(posedge core_clk) begin
    if (srst) begin
      timeout <= TIMEOUT_RESET; // [R2]
    end else if (wr_timeout && timeout_ok) begin // [R5]
      timeout <= req.wdata[LO_MSB:0];
    end
  end

  // Disable register; key value at reset keeps the watchdog off
  always_ff @(posedge core_clk) begin
    if (srst) begin
      disable_reg <= DISABLE_KEY; // [R11]
    end else if (wr_disable) begin
      disable_reg <= req.wdata; // [R9]
    end
  end

  // Live count: loaded on enable or kick, decremented per tick
  assign expire = enabled && tick && (count <= 16'h0001);
  always_ff @(posedge core_clk) begin
    if (srst) begin
      count <= COUNT_RESET;
    end else if (wr_disable && req.wdata == DISABLE_KEY) begin
      count <= COUNT_RESET; // [R10]
    end else if (wr_disable && req.wdata == ENABLE_VALUE && !enabled) begin
      count <= timeout; // [R9]
    end else if (wr_timeout && timeout_ok) begin
      count <= req.wdata[LO_MSB:0]; // [R6]
    end else if (expire) begin
      count <= timeout; // Reload so the tile reset is one pulse
    end else if (tick && count != 16'h0000) begin
      count <= count - 16'h0001; // [R1]
    end
  end

  // Tile reset pulse on expiry
  always_ff @(posedge core_clk) begin
    if (srst) begin
      tile_reset <= 1'b0;
    end else begin
      tile_reset <= expire; // [R7]
    end
  end

  // Answer: ACK or NACK one cycle after each access
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rsp <= '0;
    end else begin
      rsp.valid <= req.valid;
      rsp.ack   <= req.valid && !(wr_timeout && !timeout_ok); // [R4]
      if (req.valid && !req.write && req.index == TIMEOUT_REG_IDX) begin
        rsp.rdata <= {count, timeout}; // [R8]
      end else if (req.valid && !req.write && req.index == DISABLE_REG_IDX) begin
        rsp.rdata <= disable_reg;
      end else begin
        rsp.rdata <= 32'h00000000;
      end
    end
  end

  // Checks
  sequence s_bad_write;
    wr_timeout && !timeout_ok;
  endsequence
  property p_nack;
    @(posedge core_clk) disable iff (srst) s_bad_write |=> rsp.valid && !rsp.ack;
  endproperty
  a_nack: assert property (p_nack) else $error("bad timeout write not nacked"); // [R4]
  property p_kick;
    @(posedge core_clk) disable iff (srst)
      (wr_timeout && timeout_ok && !wr_disable) |=> count == $past(req.wdata[LO_MSB:0]);
  endproperty
  a_kick: assert property (p_kick) else $error("kick did not load count"); // [R6]
  property p_key;
    @(posedge core_clk) disable iff (srst)
      (wr_disable && req.wdata == DISABLE_KEY) |=> count == 16'h0000 && !enabled;
  endproperty
  a_key: assert property (p_key) else $error("key did not stop watchdog"); // [R10]
  property p_freeze;
    @(posedge core_clk) disable iff (srst)
      (!active_power_state && !req.valid) |=> $stable(count);
  endproperty
  a_freeze: assert property (p_freeze) else $error("count moved while asleep"); // [R3]
  property p_expire;
    @(posedge core_clk) disable iff (srst) expire |=> tile_reset;
  endproperty
  a_expire: assert property (p_expire) else $error("expiry gave no reset"); // [R7]
  property p_off;
    @(posedge core_clk) disable iff (srst) !enabled |=> !tile_reset;
  endproperty
  a_off: assert property (p_off) else $error("reset while disabled"); // [R11]
  property p_read;
    @(posedge core_clk) disable iff (srst)
      (req.valid && !req.write && req.index == TIMEOUT_REG_IDX)
      |=> rsp.rdata == {$past(count), $past(timeout)};
  endproperty
  a_read: assert property (p_read) else $error("read shows wrong count"); // [R8]
  property p_dec;
    @(posedge core_clk) disable iff (srst)
      (tick && !expire && !req.valid && count != 16'h0000) |=> count == $past(count) - 16'h0001;
  endproperty
  a_dec: assert property (p_dec) else $error("tick did not decrement"); // [R1]
endmodule : millisecond_watchdog
`default_nettype wire

//--- src/wdog_pkg.sv
// Constants and carrier types for the millisecond watchdog
package wdog_pkg;
  // Register indices (byte address is not used; access is by index)
  localparam logic [7:0]  TIMEOUT_REG_IDX   = 8'hD6;
  localparam logic [7:0]  DISABLE_REG_IDX   = 8'hD7;
  localparam logic [31:0] DISABLE_KEY       = 32'h0D15AB1E;
  localparam logic [31:0] ENABLE_VALUE      = 32'h00000000;
  localparam logic [15:0] TIMEOUT_RESET     = 16'h03E8;
  localparam logic [15:0] COUNT_RESET       = 16'h0000;
  // Oscillator frequency setting, whole MHz
  localparam logic [6:0]  FREQ_MHZ_RESET    = 7'h19;
  localparam logic [6:0]  FREQ_MHZ_MIN      = 7'h05;
  localparam logic [6:0]  FREQ_MHZ_MAX      = 7'h64;
  // Tick period: 1 ms is 1000 us, one us is FREQ_MHZ clocks
  localparam int          TICK_US           = 1000;
  localparam logic [9:0]  TICK_US_LAST      = 10'(TICK_US - 1);
  localparam int          LO_MSB            = 15;
  localparam int          HI_LSB            = 16;

  // Register access request
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [7:0]  index;
    logic [31:0] wdata;
  } reg_req_t;

  // Register access answer
  typedef struct packed {
    logic        valid;
    logic        ack;
    logic [31:0] rdata;
  } reg_rsp_t;
endpackage : wdog_pkg

//--- verification/millisecond_watchdog_tb.sv
// Self-checking bench for the millisecond watchdog
`timescale 1ns/10ps
`default_nettype none
module millisecond_watchdog_tb;
  import wdog_pkg::*;
  // Stimulus, observation and bookkeeping
  localparam int TICK = 5 * TICK_US;
  logic          core_clk;
  logic          srst;
  reg_req_t      req;
  reg_rsp_t      rsp;
  reg_rsp_t      got;
  logic          active_power_state;
  logic [6:0]    osc_freq_mhz;
  logic          tile_reset;
  int            error_cnt;
  int            check_count;
  int            cyc;
  int            n;

  millisecond_watchdog dut (.core_clk(core_clk), .srst(srst), .req(req), .rsp(rsp),
    .active_power_state(active_power_state), .osc_freq_mhz(osc_freq_mhz),
    .tile_reset(tile_reset));

  // 200 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // One access; the answer stands only in the cycle after the request
  task automatic acc(input logic wr, input logic [7:0] idx, input logic [31:0] d);
    @(posedge core_clk);
    req <= '{1'b1, wr, idx, d};
    @(posedge core_clk);
    req <= '0;
    #1;
    got = rsp;
    chk("rsp valid", 32'h1, {31'h0, got.valid});
  endtask : acc

  task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
    acc(1'b0, idx, 32'h0);
    chk("rdata", exp, got.rdata);
  endtask : rd

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : final_report

  // Hang guard, well above the longest expected run
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      error_cnt++;
      final_report();
    end
  end

  initial begin
    srst = 1'b1;
    req = '0;
    active_power_state = 1'b1;
    osc_freq_mhz = FREQ_MHZ_MIN;
    error_cnt = 0;
    check_count = 0;
    cyc = 0;
    repeat (16) @(posedge core_clk);
    srst <= 1'b0;
    rd(TIMEOUT_REG_IDX, {COUNT_RESET, TIMEOUT_RESET});
    rd(DISABLE_REG_IDX, DISABLE_KEY);
    repeat (TICK + 10) @(posedge core_clk);
    rd(TIMEOUT_REG_IDX, {COUNT_RESET, TIMEOUT_RESET});
    $display("test reset done");
    // Upper half not the complement: must be refused and change nothing
    acc(1'b1, TIMEOUT_REG_IDX, 32'h0002_0002);
    chk("nack", 32'h0, {31'h0, got.ack});
    rd(TIMEOUT_REG_IDX, {COUNT_RESET, TIMEOUT_RESET});
    acc(1'b1, DISABLE_REG_IDX, ENABLE_VALUE);
    rd(TIMEOUT_REG_IDX, {TIMEOUT_RESET, TIMEOUT_RESET});
    acc(1'b1, TIMEOUT_REG_IDX, {~16'h0002, 16'h0002});
    chk("ack", 32'h1, {31'h0, got.ack});
    repeat (TICK - 40) @(posedge core_clk);
    rd(TIMEOUT_REG_IDX, 32'h0002_0002);
    repeat (40) @(posedge core_clk);
    rd(TIMEOUT_REG_IDX, 32'h0001_0002);
    $display("test countdown done");
    // Leaving the active state must freeze the count
    @(posedge core_clk) active_power_state <= 1'b0;
    repeat (TICK + 100) @(posedge core_clk);
    rd(TIMEOUT_REG_IDX, 32'h0001_0002);
    @(posedge core_clk) active_power_state <= 1'b1;
    n = 0;
    while (tile_reset !== 1'b1 && n < TICK + 100) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk("tile_reset", 32'h1, {31'h0, tile_reset});
    rd(TIMEOUT_REG_IDX, 32'h0002_0002);
    $display("test expiry done");
    acc(1'b1, DISABLE_REG_IDX, DISABLE_KEY);
    rd(TIMEOUT_REG_IDX, 32'h0000_0002);
    repeat (2 * TICK) @(posedge core_clk);
    rd(TIMEOUT_REG_IDX, 32'h0000_0002);
    rd(8'h00, 32'h0);
    $display("test disable done");
    final_report();
  end
endmodule : millisecond_watchdog_tb
`default_nettype wire
